// ---- rtl/tgo_pkg.sv ----
package tgo_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_CORE_CTRL = 12'h000;
  localparam logic [11:0] OFS_LOW_CTRL = 12'h004;
  localparam logic [11:0] OFS_HIGH_CTRL = 12'h008;
  localparam logic [11:0] OFS_CORE_CNT = 12'h00C;
  localparam logic [11:0] OFS_LOW_CNT = 12'h010;
  localparam logic [11:0] OFS_HIGH_CNT = 12'h014;
  localparam logic [11:0] OFS_CORE_IC = 12'h018;
  localparam logic [11:0] OFS_LOW_IC = 12'h01C;
  localparam logic [11:0] OFS_HIGH_IC = 12'h020;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h024;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h028;
  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int CTL_PRE_LSB = 0;   // 3 bits prescaler select
  localparam int CTL_MODE_LSB = 3;  // 2 bits mode
  localparam int CTL_RUN = 5;
  localparam int CTL_DOWN = 6;
  localparam int CTL_EXTDIR = 7;
  localparam int CTL_OUTEN = 8;     // core only
  localparam int CTL_LATCH = 9;     // core only, latch value (read)
  localparam int CTL_ROLE_LSB = 8;  // aux only, 2 bits role
  localparam int CTL_TRIG_LSB = 10; // aux only, 2 bits reload trigger
  localparam int CTL_TLCLK = 12;    // aux only, count on latch edges
  localparam int IC_REQ = 0;
  localparam int IC_EN = 1;
  localparam int IC_PRI_LSB = 2;    // 4 bits priority
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [12:0] CTRL_RESET = 13'h0000;
  localparam logic [5:0] IC_RESET = 6'h00;
  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_GATED = 2'b01,
    MODE_COUNTER = 2'b10,
    MODE_INCR = 2'b11
  } tgo_mode_t;
  typedef enum logic [1:0] {
    ROLE_NONE = 2'b00,
    ROLE_CAPTURE = 2'b01,
    ROLE_RELOAD = 2'b10
  } tgo_role_t;
  // reload trigger: pin edge, latch rise, latch fall, either latch edge
  typedef enum logic [1:0] {
    TRIG_PIN = 2'b00,
    TRIG_RISE = 2'b01,
    TRIG_FALL = 2'b10,
    TRIG_BOTH = 2'b11
  } tgo_trig_t;
endpackage

// ---- rtl/tgo_timer_group.sv ----
// Behaviour
// [RULE1] three independent 16-bit up/down counters, chainable via the latch
// [RULE2] each timer selects timer, gated, counter or incremental mode
// [RULE3] timer mode counts cpu clock divided by 8 to 1024, 3-bit code
// [RULE4] same prescaler for core gated mode and aux timer/gated modes
// [RULE5] counter mode advances on edges of the timer's input pin; the code counts rising edges only
// [RULE6] gated mode counts prescaled ticks only while gate pin is high
// [RULE7] one input pin per timer serves as gate or count clock
// [RULE8] direction from software bit, optionally flipped by direction pin
// [RULE9] incremental mode decodes pins as quadrature channels A and B
// [RULE10] core toggle latch inverts on every core overflow or underflow
// [RULE11] core toggle latch can drive an output pin
// [RULE12] core toggle latch may clock either aux timer
// [RULE13] aux timer as capture or reload register stops counting
// [RULE14] capture role copies core value on input pin transition
// [RULE15] reload role loads core on pin edge or chosen latch transition
// [RULE16] both aux timers may reload core on opposite latch edges
// [RULE17] per-timer interrupt control: request, enable, 16-level priority
// [RULE18] request flag set on wrap past all-ones or below zero
// [RULE19] reset: zero, stopped, up, timer mode, latch clear, roles off
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tgo_timer_group
  import tgo_pkg::*;
(
  input wire logic clock,          // 10 MHz cpu clock
  input wire logic srst,           // synchronous reset, active high
  input wire logic psel,           // apb select
  input wire logic penable,        // apb access phase
  input wire logic pwrite,         // apb direction
  input wire logic [11:0] paddr,   // apb byte address
  input wire logic [31:0] pwdata,  // apb write data
  output logic [31:0] prdata,      // apb read data
  output logic pready,             // apb ready
  output logic pslverr,            // apb error, unmapped address
  input wire logic [2:0] timer_gate_count_input, // 0 low, 1 core, 2 high
  input wire logic [2:0] timer_direction_input,  // per-timer direction/B
  output logic toggle_latch_output_pin,          // core latch when enabled
  output logic [2:0] timer_irq_req,              // per-timer request flags gated by enable
  output logic [11:0] timer_irq_pri,             // 4-bit priority per timer
  output logic irq                               // unmasked status pending
);
  localparam int NT = 3;
  localparam int CORE = 1;
  // ------------------------------------------------------------
  // pin synchronisers: three stages, change taken when 2 and 3 agree
  // ------------------------------------------------------------
  logic [NT-1:0] in_s1, in_s2, in_s3, in_q;
  logic [NT-1:0] dir_s1, dir_s2, dir_s3, dir_q;
  // gate / count pins
  always_ff @(posedge clock) begin
    if (srst) begin
      in_s1 <= '0;
      in_s2 <= '0;
      in_s3 <= '0;
    end else begin
      in_s1 <= timer_gate_count_input;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end
  // direction / channel b pins
  always_ff @(posedge clock) begin
    if (srst) begin
      dir_s1 <= '0;
      dir_s2 <= '0;
      dir_s3 <= '0;
    end else begin
      dir_s1 <= timer_direction_input;
      dir_s2 <= dir_s1;
      dir_s3 <= dir_s2;
    end
  end
  // two stages must agree, so a one-cycle glitch never counts
  always_ff @(posedge clock) begin
    if (srst) begin
      in_q <= '0;
    end else begin
      for (int i = 0; i < NT; i++) begin
        if (in_s2[i] == in_s3[i])
          in_q[i] <= in_s3[i];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      dir_q <= '0;
    end else begin
      for (int i = 0; i < NT; i++) begin
        if (dir_s2[i] == dir_s3[i])
          dir_q[i] <= dir_s3[i];
      end
    end
  end
  // one-cycle delayed copies for edge detection
  logic [NT-1:0] in_d, dir_d;
  always_ff @(posedge clock) begin
    if (srst)
      in_d <= '0;
    else
      in_d <= in_q;
  end
  always_ff @(posedge clock) begin
    if (srst)
      dir_d <= '0;
    else
      dir_d <= dir_q;
  end
  // ------------------------------------------------------------
  // prescaler: free 10-bit divider, tick per selected factor
  // ------------------------------------------------------------
  logic [9:0] pre_cnt;
  always_ff @(posedge clock) begin
    if (srst)
      pre_cnt <= '0;
    else
      pre_cnt <= pre_cnt + 10'h001;
  end
  // factor 8 << sel: tick when the low (3+sel) bits are all ones
  function automatic logic pre_tick(input logic [2:0] sel,
                                    input logic [9:0] cnt);
    logic [9:0] m;
    m = 10'(10'h3FF >> (3'h7 - sel));
    return (cnt & m) == m; // see [RULE3]
  endfunction
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [12:0] ctrl [NT];
  logic [15:0] cnt [NT];
  logic [5:0] icr [NT];
  logic [NT-1:0] irq_stat, irq_mask;
  logic core_latch, core_latch_d;
  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  function automatic logic mapped(input logic [11:0] a);
    case (a)
      OFS_CORE_CTRL, OFS_LOW_CTRL, OFS_HIGH_CTRL,
      OFS_CORE_CNT, OFS_LOW_CNT, OFS_HIGH_CNT,
      OFS_CORE_IC, OFS_LOW_IC, OFS_HIGH_IC,
      OFS_IRQ_STAT, OFS_IRQ_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  assign pslverr = psel && penable && !mapped(paddr);
  // slot of a per-timer register from its base, 0 core, 1 low, 2 high
  function automatic int unsigned tidx(input logic [11:0] a,
                                       input logic [11:0] base);
    return int'((a - base) >> 2);
  endfunction
  // interrupt control offset of timer i; same map as the read mux
  function automatic logic [11:0] ic_ofs(input int i);
    case (i)
      0: return OFS_LOW_IC;
      CORE: return OFS_CORE_IC;
      default: return OFS_HIGH_IC;
    endcase
  endfunction
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < NT; i++)
        ctrl[i] <= CTRL_RESET; // see [RULE19]
    end else if (wr_en) begin
      // order on the bus: core, low, high
      if (paddr == OFS_LOW_CTRL)
        ctrl[0] <= pwdata[12:0];
      if (paddr == OFS_CORE_CTRL)
        ctrl[CORE] <= {3'h0, pwdata[9:0]};
      if (paddr == OFS_HIGH_CTRL)
        ctrl[2] <= pwdata[12:0];
    end
  end
  // ------------------------------------------------------------
  // per-timer count enable and direction
  // ------------------------------------------------------------
  logic latch_rise, latch_fall;
  assign latch_rise = core_latch && !core_latch_d;
  assign latch_fall = !core_latch && core_latch_d;
  logic [NT-1:0] step, down;
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      logic tk;
      logic ea, eb;
      tk = pre_tick(ctrl[i][CTL_PRE_LSB +: 3], pre_cnt);
      ea = in_q[i] ^ in_d[i];
      eb = dir_q[i] ^ dir_d[i];
      // see [RULE8]
      down[i] = ctrl[i][CTL_DOWN] ^ (ctrl[i][CTL_EXTDIR] & dir_q[i]);
      step[i] = 1'b0;
      unique case (tgo_mode_t'(ctrl[i][CTL_MODE_LSB +: 2])) // see [RULE2]
        MODE_TIMER: step[i] = tk; // see [RULE3]
        MODE_GATED: step[i] = tk && in_q[i]; // see [RULE4] see [RULE6]
        MODE_COUNTER: step[i] = in_q[i] && !in_d[i]; // see [RULE5] [RULE7]
        MODE_INCR: begin
          // x4 decode per edge of either channel, direction from phase
          step[i] = ea || eb; // see [RULE9]
          down[i] = ea ? (in_q[i] == dir_q[i]) : (in_q[i] != dir_q[i]);
        end
      endcase
      if (i != CORE && ctrl[i][CTL_TLCLK])
        step[i] = latch_rise || latch_fall; // see [RULE12]
      if (i != CORE && ctrl[i][CTL_ROLE_LSB +: 2] != ROLE_NONE)
        step[i] = 1'b0; // see [RULE13]
      if (!ctrl[i][CTL_RUN])
        step[i] = 1'b0;
    end
  end
  // ------------------------------------------------------------
  // capture / reload triggers
  // ------------------------------------------------------------
  function automatic logic reload_hit(input logic [12:0] c,
                                      input logic pin_edge,
                                      input logic lr, input logic lf);
    if (tgo_role_t'(c[CTL_ROLE_LSB +: 2]) != ROLE_RELOAD)
      return 1'b0;
    unique case (tgo_trig_t'(c[CTL_TRIG_LSB +: 2]))
      TRIG_PIN: return pin_edge;
      TRIG_RISE: return lr; // see [RULE16]
      TRIG_FALL: return lf;
      TRIG_BOTH: return lr || lf;
    endcase
  endfunction
  logic [NT-1:0] pin_edge;
  assign pin_edge = in_q ^ in_d;
  logic rl_low, rl_high, cap_low, cap_high;
  assign rl_low = reload_hit(ctrl[0], pin_edge[0], latch_rise, latch_fall);
  assign rl_high = reload_hit(ctrl[2], pin_edge[2], latch_rise, latch_fall);
  assign cap_low = ctrl[0][CTL_ROLE_LSB +: 2] == ROLE_CAPTURE && pin_edge[0];
  assign cap_high = ctrl[2][CTL_ROLE_LSB +: 2] == ROLE_CAPTURE &&
                    pin_edge[2];
  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  logic [NT-1:0] wrap;
  always_comb begin
    for (int i = 0; i < NT; i++)
      wrap[i] = step[i] && (down[i] ? cnt[i] == 16'h0000
                                    : cnt[i] == 16'hFFFF); // see [RULE18]
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < NT; i++)
        cnt[i] <= CNT_RESET; // see [RULE19]
    end else begin
      for (int i = 0; i < NT; i++) begin
        if (step[i])
          cnt[i] <= down[i] ? cnt[i] - 16'h0001
                            : cnt[i] + 16'h0001; // see [RULE1]
      end
      // reload wins over capture and counting; low before high
      if (rl_low)
        cnt[CORE] <= cnt[0]; // see [RULE15]
      else if (rl_high)
        cnt[CORE] <= cnt[2]; // see [RULE15]
      if (cap_low)
        cnt[0] <= cnt[CORE]; // see [RULE14]
      if (cap_high)
        cnt[2] <= cnt[CORE]; // see [RULE14]
      if (wr_en && paddr == OFS_LOW_CNT)
        cnt[0] <= pwdata[15:0];
      if (wr_en && paddr == OFS_CORE_CNT)
        cnt[CORE] <= pwdata[15:0];
      if (wr_en && paddr == OFS_HIGH_CNT)
        cnt[2] <= pwdata[15:0];
    end
  end
  // ------------------------------------------------------------
  // core toggle latch
  // ------------------------------------------------------------
  // a wrap beats a software write of the latch bit
  always_ff @(posedge clock) begin
    if (srst) begin
      core_latch <= 1'b0; // see [RULE19]
    end else if (wrap[CORE]) begin
      core_latch <= !core_latch; // see [RULE10]
    end else if (wr_en && paddr == OFS_CORE_CTRL) begin
      core_latch <= pwdata[CTL_LATCH];
    end
  end
  always_ff @(posedge clock) begin
    if (srst)
      core_latch_d <= 1'b0;
    else
      core_latch_d <= core_latch;
  end
  logic core_latch_q_out;
  assign toggle_latch_output_pin = core_latch_q_out;
  always_ff @(posedge clock) begin
    if (srst)
      core_latch_q_out <= 1'b0;
    else
      core_latch_q_out <= core_latch && ctrl[CORE][CTL_OUTEN]; // see [RULE11]
  end
  // ------------------------------------------------------------
  // interrupt control: set wins over software clear
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < NT; i++)
        icr[i] <= IC_RESET;
    end else begin
      for (int i = 0; i < NT; i++) begin
        if (wr_en && paddr == ic_ofs(i))
          icr[i] <= pwdata[5:0];
        if (wrap[i])
          icr[i][IC_REQ] <= 1'b1; // see [RULE17] see [RULE18]
      end
    end
  end
  // sticky status, cleared by reading it; a new event in that cycle stays
  logic stat_rd;
  assign stat_rd = rd_en && paddr == OFS_IRQ_STAT;
  always_ff @(posedge clock) begin
    if (srst)
      irq_stat <= '0;
    else
      irq_stat <= (stat_rd ? '0 : irq_stat) | wrap;
  end
  always_ff @(posedge clock) begin
    if (srst)
      irq_mask <= '0;
    else if (wr_en && paddr == OFS_IRQ_MASK)
      irq_mask <= pwdata[NT-1:0];
  end
  assign irq = |(irq_stat & irq_mask);
  // ------------------------------------------------------------
  // per-timer interrupt outputs
  // ------------------------------------------------------------
  // priority only passed on; arbitration sits in the interrupt controller
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      timer_irq_req[i] = icr[i][IC_REQ] && icr[i][IC_EN];
      timer_irq_pri[4*i +: 4] = icr[i][IC_PRI_LSB +: 4];
    end
  end
  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        OFS_LOW_CTRL: prdata = {19'h0, ctrl[0]};
        OFS_CORE_CTRL: prdata = {22'h0, core_latch, ctrl[CORE][8:0]};
        OFS_HIGH_CTRL: prdata = {19'h0, ctrl[2]};
        OFS_LOW_CNT, OFS_CORE_CNT, OFS_HIGH_CNT:
          prdata = {16'h0, cnt[tidx(paddr, OFS_CORE_CNT) == 0 ? 1 :
                              tidx(paddr, OFS_CORE_CNT) == 1 ? 0 : 2]};
        OFS_LOW_IC: prdata = {26'h0, icr[0]};
        OFS_CORE_IC: prdata = {26'h0, icr[CORE]};
        OFS_HIGH_IC: prdata = {26'h0, icr[2]};
        OFS_IRQ_STAT: prdata = {29'h0, irq_stat};
        OFS_IRQ_MASK: prdata = {29'h0, irq_mask};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- dv/tgo_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module tgo_props
  import tgo_pkg::*;
(
  input wire logic clock, // cpu clock
  input wire logic srst, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [2:0] timer_gate_count_input, // gate pins
  input wire logic [2:0] timer_direction_input, // direction pins
  input wire logic toggle_latch_output_pin, // latch pin
  input wire logic [2:0] timer_irq_req, // request flags
  input wire logic [11:0] timer_irq_pri, // priorities
  input wire logic irq // interrupt
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  logic mapped;
  assign mapped = (paddr <= OFS_IRQ_MASK) && (paddr[1:0] == 2'h0);
  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_ready;
    s_setup ##1 s_access |-> pready;
  endproperty
  property p_err_bad;
    psel && penable && !mapped |-> pslverr;
  endproperty
  property p_err_ok;
    psel && penable && mapped |-> !pslverr;
  endproperty
  property p_err_idle;
    !(psel && penable) |-> !pslverr;
  endproperty
  property p_rst;
    $fell(srst) |-> !irq && timer_irq_req == 3'h0
      && !toggle_latch_output_pin && timer_irq_pri == 12'h000;
  endproperty
  property p_pri;
    $changed(timer_irq_pri) |-> $past(psel && penable && pwrite);
  endproperty
  property p_req_fall;
    |($past(timer_irq_req) & ~timer_irq_req) |->
      $past(psel && penable && pwrite);
  endproperty
  property p_irq_fall;
    $fell(irq) |-> $past(psel && penable);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  a_err_bad: assert property (p_err_bad) else $error("no error unmapped");
  a_err_ok: assert property (p_err_ok) else $error("error on mapped");
  a_err_idle: assert property (p_err_idle) else $error("error idle");
  a_rst: assert property (p_rst)
    else $error("outputs after reset");
  a_pri: assert property (p_pri)
    else $error("priority moved");
  a_req_fall: assert property (p_req_fall)
    else $error("req fell");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
endmodule
bind tgo_timer_group tgo_props u_props (.clock(clock), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_gate_count_input(timer_gate_count_input),
  .timer_direction_input(timer_direction_input),
  .toggle_latch_output_pin(toggle_latch_output_pin),
  .timer_irq_req(timer_irq_req), .timer_irq_pri(timer_irq_pri),
  .irq(irq));
`default_nettype wire

// ---- dv/tgo_sensor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tgo_sensor_model (
  input wire logic clock, // cpu clock
  output logic [2:0] gate_pin, // gate or count pins
  output logic [2:0] dir_pin // direction or channel b pins
);
  int phase;
  initial begin
    gate_pin = 3'h0;
    dir_pin = 3'h0;
    phase = 0;
  end
  // long holds so the pin synchronisers never miss a level
  task automatic hold(input int len);
    repeat (len) @(posedge clock);
  endtask
  task automatic pulse(input int idx, input int n, input int len);
    repeat (n) begin
      gate_pin[idx] <= 1'b1;
      hold(len);
      gate_pin[idx] <= 1'b0;
      hold(len);
    end
  endtask
  task automatic set_dir(input int idx, input logic v);
    dir_pin[idx] <= v;
    hold(10);
  endtask
  // gray steps a,b: 00 10 11 01 forward
  task automatic quad(input int n, input logic fwd);
    repeat (n) begin
      phase = fwd ? phase + 1 : phase + 3;
      gate_pin[1] <= (phase % 4 == 1) || (phase % 4 == 2);
      dir_pin[1] <= (phase % 4 >= 2);
      hold(10);
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/tgo_timer_group_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module tgo_timer_group_bench;
  import tgo_pkg::*;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, irq, latch_pin;
  logic [11:0] paddr, irq_pri;
  logic [31:0] pwdata, prdata;
  logic [2:0] gate_pin, dir_pin, irq_req;
  logic [32:0] q_lo[$], q_hi[$], q_alt[$];
  logic [15:0] val;
  int num_errors, check_count, seed;
  tgo_sensor_model u_model (.clock(clock), .gate_pin(gate_pin),
    .dir_pin(dir_pin));
  tgo_timer_group u_dut (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_gate_count_input(gate_pin), .timer_direction_input(dir_pin),
    .toggle_latch_output_pin(latch_pin), .timer_irq_req(irq_req),
    .timer_irq_pri(irq_pri), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [32:0] got, lo, hi, alt);
    check_count++;
    if (((got >= lo && got <= hi) || got === alt) !== 1'b1) begin
      num_errors++;
      $display("FAIL %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  // ----------------------------------------
  // apb master, one idle cycle between transfers
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("FAIL %0t no ready", $time);
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] lo, hi,
                    input logic [32:0] alt = '1);
    q_lo.push_back(lo);
    q_hi.push_back(hi);
    q_alt.push_back(alt);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic pin(input logic got, input logic exp);
    check({32'h0, got}, {32'h0, exp}, {32'h0, exp}, '1);
  endtask
  // read results checked in order as they appear on the bus
  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite && q_lo.size() > 0) begin
      check({pslverr, prdata}, q_lo.pop_front(), q_hi.pop_front(),
            q_alt.pop_front());
    end
  end
  initial begin
    seed = 32'h756F2131;
    srst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    for (int a = 0; a < 24; a += 4) rd(12'(a), 33'h0, 33'h0);
    rd(12'h02C, 33'h100000000, 33'h100000000);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CORE_CNT, 32'h0);
      wr(OFS_CORE_CTRL, 32'h20 | c);
      repeat ((8 << c) * 3 - 4) @(posedge clock);
      wr(OFS_CORE_CTRL, 32'(c));
      rd(OFS_CORE_CNT, 33'h2, 33'h3);
    end
    $display("test prescaler done");
    wr(OFS_IRQ_MASK, 32'h7);
    wr(OFS_CORE_CNT, 32'h0);
    wr(OFS_CORE_CTRL, 32'h160);
    repeat (20) @(posedge clock);
    pin(latch_pin, 1'b1);
    wr(OFS_CORE_CTRL, 32'h340);
    rd(OFS_CORE_CNT, 33'hFFFD, 33'hFFFE);
    wr(OFS_IRQ_MASK, 32'h0);
    pin(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h7);
    pin(irq, 1'b1);
    rd(OFS_IRQ_STAT, 33'h2, 33'h2);
    pin(irq, 1'b0);
    rd(OFS_CORE_IC, 33'h1, 33'h1);
    pin(irq_req[1], 1'b0);
    wr(OFS_CORE_IC, 32'h3F);
    pin(irq_req[1], 1'b1);
    check({21'h0, irq_pri}, 33'h0F0, 33'h0F0, '1);
    wr(OFS_CORE_IC, 32'h0);
    pin(irq_req[1], 1'b0);
    $display("test underflow done");
    wr(OFS_LOW_CTRL, 32'h30);
    u_model.pulse(0, 5, 10);
    rd(OFS_LOW_CNT, 33'h5, 33'h5);
    wr(OFS_LOW_CTRL, 32'hB0);
    u_model.set_dir(0, 1'b1);
    u_model.pulse(0, 3, 10);
    rd(OFS_LOW_CNT, 33'h2, 33'h2);
    $display("test counter done");
    wr(OFS_HIGH_CTRL, 32'h28);
    u_model.pulse(2, 1, 80);
    rd(OFS_HIGH_CNT, 33'h9, 33'hB);
    $display("test gated done");
    wr(OFS_CORE_CTRL, 32'h0);
    wr(OFS_CORE_CNT, 32'h0);
    wr(OFS_CORE_CTRL, 32'h38);
    u_model.quad(4, 1'b1);
    rd(OFS_CORE_CNT, 33'h4, 33'h4, 33'hFFFC);
    u_model.quad(4, 1'b0);
    rd(OFS_CORE_CNT, 33'h0, 33'h0);
    $display("test quadrature done");
    wr(OFS_CORE_CTRL, 32'h0);
    val = 16'($random(seed));
    wr(OFS_CORE_CNT, {16'h0, val});
    wr(OFS_LOW_CTRL, 32'h130);
    u_model.pulse(0, 1, 10);
    rd(OFS_LOW_CNT, {17'h0, val}, {17'h0, val});
    val = 16'($random(seed));
    wr(OFS_HIGH_CTRL, 32'h200);
    wr(OFS_HIGH_CNT, {16'h0, val});
    u_model.pulse(2, 1, 10);
    rd(OFS_CORE_CNT, {17'h0, val}, {17'h0, val});
    $display("test capture reload done");
    wr(OFS_LOW_CTRL, 32'h600);
    wr(OFS_LOW_CNT, 32'hFFFA);
    wr(OFS_HIGH_CTRL, 32'hA00);
    wr(OFS_HIGH_CNT, 32'hFFF0);
    wr(OFS_CORE_CNT, 32'hFFFF);
    wr(OFS_CORE_CTRL, 32'h320);
    // latch set by the write: rise loads FFFA, wrap falls and loads FFF0
    repeat (70) @(posedge clock);
    pin(latch_pin, 1'b0);
    wr(OFS_CORE_CTRL, 32'h100);
    rd(OFS_CORE_CNT, 33'hFFF3, 33'hFFF3);
    $display("test latch reload done");
    finish_test();
  end
endmodule
`default_nettype wire
